// file: dtcu_timer_unit.v
`timescale 1ns/1ns
`default_nettype none
`include "dtcu_regs.vh"

module dtcu_timer_unit (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_n_i,
    // special function register port
    input  wire [7:0] sfr_addr_i,
    input  wire       sfr_wr_i,
    input  wire [7:0] sfr_wdata_i,
    input  wire       sfr_rd_i,
    input  wire       sfr_bit_wr_i,
    input  wire [2:0] sfr_bit_sel_i,
    input  wire       sfr_bit_val_i,
    output reg  [7:0] sfr_rdata_o,
    // interrupt vector acknowledges
    input  wire       first_vector_ack_i,
    input  wire       second_vector_ack_i,
    // external pins
    input  wire       first_count_input_i,
    input  wire       second_count_input_i,
    input  wire       first_ext_irq_pin_i,
    input  wire       second_ext_irq_pin_i,
    // overflow flags toward the interrupt controller
    output wire       first_overflow_flag_o,
    output wire       second_overflow_flag_o
);

    // -----------------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------------
    reg  [7:0] timer_control_reg;
    reg  [7:0] timer_mode_reg;
    reg  [7:0] count_low_byte0_reg;
    reg  [7:0] count_high_byte0_reg;
    reg  [7:0] count_low_byte1_reg;
    reg  [7:0] count_high_byte1_reg;
    reg  [3:0] phase_reg;
    reg        pend0_reg;
    reg        pend1_reg;

    wire       sample_ph;
    wire       update_ph;
    wire [3:0] pin_raw;
    wire [3:0] pin_level;
    wire [3:0] pin_fall;

    // -----------------------------------------------------------------------
    // machine cycle phase counter
    // -----------------------------------------------------------------------

    // twelve core clocks per machine cycle
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            phase_reg <= `DTCU_PHASE_ZERO;
        end else if (phase_reg == `DTCU_PHASE_LAST) begin
            phase_reg <= `DTCU_PHASE_ZERO;
        end else begin
            phase_reg <= phase_reg + 4'h1;
        end
    end

    assign sample_ph = (phase_reg == `DTCU_SAMPLE_PHASE);
    assign update_ph = (phase_reg == `DTCU_UPDATE_PHASE);

    // -----------------------------------------------------------------------
    // pin samplers: 0/1 count inputs, 2/3 interrupt pins used as gates
    // -----------------------------------------------------------------------
    assign pin_raw = {second_ext_irq_pin_i, first_ext_irq_pin_i,
                      second_count_input_i, first_count_input_i};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
            dtcu_pin_sampler u_samp (
                .ref_clk_i (ref_clk_i),
                .rst_n_i   (rst_n_i),
                .pin_i     (pin_raw[gi]),
                .sample_i  (sample_ph),
                .level_o   (pin_level[gi]),
                .fall_o    (pin_fall[gi])
            );
        end
    endgenerate

    // -----------------------------------------------------------------------
    // detected edges wait for the update phase of the next machine cycle
    // -----------------------------------------------------------------------

    // edge from sample phase held until next update phase
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            pend0_reg <= 1'b0;
            pend1_reg <= 1'b0;
        end else begin
            if (pin_fall[0]) begin
                pend0_reg <= 1'b1;
            end else if (update_ph) begin
                pend0_reg <= 1'b0;
            end
            if (pin_fall[1]) begin
                pend1_reg <= 1'b1;
            end else if (update_ph) begin
                pend1_reg <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // mode field decode
    // -----------------------------------------------------------------------
    wire       gate0 = timer_mode_reg[`DTCU_MF_GATE];
    wire       sel0  = timer_mode_reg[`DTCU_MF_SEL];
    wire [1:0] mode0 = timer_mode_reg[`DTCU_MF_MODE_HI:`DTCU_MF_MODE_LO];
    wire       gate1 = timer_mode_reg[`DTCU_MF_GATE + `DTCU_MF_NIB1];
    wire       sel1  = timer_mode_reg[`DTCU_MF_SEL + `DTCU_MF_NIB1];
    wire [1:0] mode1 = timer_mode_reg[`DTCU_MF_MODE_HI + `DTCU_MF_NIB1:`DTCU_MF_MODE_LO + `DTCU_MF_NIB1];
    wire       run0  = timer_control_reg[`DTCU_CTRL_RUN0];
    wire       run1  = timer_control_reg[`DTCU_CTRL_RUN1];
    wire       split = (mode0 == `DTCU_MODE_SPLIT);

    // -----------------------------------------------------------------------
    // count enables
    // -----------------------------------------------------------------------

    // gating by interrupt pin, source select, run bit
    wire en0   = run0 & (~gate0 | pin_level[2]);
    wire en1   = run1 & (~gate1 | pin_level[3]);
    wire src0  = sel0 ? pend0_reg : 1'b1;
    wire src1  = sel1 ? pend1_reg : 1'b1;
    wire tick0 = update_ph & en0 & src0;
    wire tick1 = update_ph & en1 & src1 & (mode1 != `DTCU_MODE_SPLIT);
    wire tickh = update_ph & run1 & split;

    // -----------------------------------------------------------------------
    // one count step: returns {overflow, high, low}
    // -----------------------------------------------------------------------
    function [16:0] dtcu_step;
        input [1:0] mode;
        input [7:0] hi;
        input [7:0] lo;
        begin
            case (mode)
                `DTCU_MODE_PRESC13: begin
                    if (lo[4:0] == `DTCU_PRESC_MAX) begin
                        dtcu_step = {(hi == `DTCU_BYTE_MAX), hi + 8'h01,
                                     lo[7:5], 5'h00};
                    end else begin
                        dtcu_step = {1'b0, hi, lo[7:5], lo[4:0] + 5'h01};
                    end
                end
                `DTCU_MODE_CASC16: begin
                    if (lo == `DTCU_BYTE_MAX) begin
                        dtcu_step = {(hi == `DTCU_BYTE_MAX), hi + 8'h01, 8'h00};
                    end else begin
                        dtcu_step = {1'b0, hi, lo + 8'h01};
                    end
                end
                `DTCU_MODE_RELOAD8: begin
                    if (lo == `DTCU_BYTE_MAX) begin
                        dtcu_step = {1'b1, hi, hi};
                    end else begin
                        dtcu_step = {1'b0, hi, lo + 8'h01};
                    end
                end
                default: begin
                    dtcu_step = {(lo == `DTCU_BYTE_MAX), hi, lo + 8'h01};
                end
            endcase
        end
    endfunction

    // -----------------------------------------------------------------------
    // next count for each timer
    // -----------------------------------------------------------------------

    // both steps formed every clock, applied only on a tick
    wire [16:0] step0 = dtcu_step(mode0, count_high_byte0_reg, count_low_byte0_reg);
    wire [16:0] step1 = dtcu_step(mode1, count_high_byte1_reg, count_low_byte1_reg);

    // -----------------------------------------------------------------------
    // overflow events
    // -----------------------------------------------------------------------

    // overflow events, wrap from all ones at mode width
    wire ovf0   = tick0 & step0[16];
    wire ovfh   = tickh & (count_high_byte0_reg == `DTCU_BYTE_MAX);
    wire ovf1   = tick1 & step1[16] & ~split;

    // -----------------------------------------------------------------------
    // register writes, byte and bit addressed
    // -----------------------------------------------------------------------
    wire wr_ctrl = sfr_wr_i & (sfr_addr_i == `DTCU_ADDR_CTRL);
    wire bw_ctrl = sfr_bit_wr_i & (sfr_addr_i == `DTCU_ADDR_CTRL);
    wire wr_mode = sfr_wr_i & (sfr_addr_i == `DTCU_ADDR_MODE);
    wire wr_lo0  = sfr_wr_i & (sfr_addr_i == `DTCU_ADDR_LO0);
    wire wr_hi0  = sfr_wr_i & (sfr_addr_i == `DTCU_ADDR_HI0);
    wire wr_lo1  = sfr_wr_i & (sfr_addr_i == `DTCU_ADDR_LO1);
    wire wr_hi1  = sfr_wr_i & (sfr_addr_i == `DTCU_ADDR_HI1);

    // software image of the control register after this cycle's write
    reg  [7:0] ctrl_sw;

    always @* begin
        ctrl_sw = timer_control_reg;
        if (wr_ctrl) begin
            ctrl_sw = sfr_wdata_i;
        end else if (bw_ctrl) begin
            ctrl_sw[sfr_bit_sel_i] = sfr_bit_val_i;
        end
    end

    // -----------------------------------------------------------------------
    // control and mode registers
    // -----------------------------------------------------------------------

    // overflow set wins over software clear and vector clear
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            timer_control_reg <= `DTCU_RST_CTRL;
            timer_mode_reg    <= `DTCU_RST_MODE;
        end else begin
            if (wr_mode) begin
                timer_mode_reg <= sfr_wdata_i;
            end
            timer_control_reg <= ctrl_sw;
            if (ovf0) begin
                timer_control_reg[`DTCU_CTRL_OVF0] <= 1'b1;
            end else if (first_vector_ack_i) begin
                timer_control_reg[`DTCU_CTRL_OVF0] <= 1'b0;
            end
            if (ovf1 | ovfh) begin
                timer_control_reg[`DTCU_CTRL_OVF1] <= 1'b1;
            end else if (second_vector_ack_i) begin
                timer_control_reg[`DTCU_CTRL_OVF1] <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------------
    // first timer count registers
    // -----------------------------------------------------------------------

    // software write takes the byte over a count in the same cycle
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            count_low_byte0_reg  <= `DTCU_RST_BYTE;
            count_high_byte0_reg <= `DTCU_RST_BYTE;
        end else begin
            if (wr_lo0) begin
                count_low_byte0_reg <= sfr_wdata_i;
            end else if (tick0) begin
                count_low_byte0_reg <= step0[7:0];
            end
            if (wr_hi0) begin
                count_high_byte0_reg <= sfr_wdata_i;
            end else if (split) begin
                if (tickh) begin
                    count_high_byte0_reg <= count_high_byte0_reg + 8'h01;
                end
            end else if (tick0) begin
                count_high_byte0_reg <= step0[15:8];
            end
        end
    end

    // -----------------------------------------------------------------------
    // second timer count registers
    // -----------------------------------------------------------------------

    // holds while in its stopped mode
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            count_low_byte1_reg  <= `DTCU_RST_BYTE;
            count_high_byte1_reg <= `DTCU_RST_BYTE;
        end else begin
            if (wr_lo1) begin
                count_low_byte1_reg <= sfr_wdata_i;
            end else if (tick1) begin
                count_low_byte1_reg <= step1[7:0];
            end
            if (wr_hi1) begin
                count_high_byte1_reg <= sfr_wdata_i;
            end else if (tick1) begin
                count_high_byte1_reg <= step1[15:8];
            end
        end
    end

    // -----------------------------------------------------------------------
    // register read port
    // -----------------------------------------------------------------------

    // read data registered, unmapped addresses read zero
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sfr_rdata_o <= `DTCU_RD_UNMAPPED;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `DTCU_ADDR_CTRL: sfr_rdata_o <= timer_control_reg;
                `DTCU_ADDR_MODE: sfr_rdata_o <= timer_mode_reg;
                `DTCU_ADDR_LO0:  sfr_rdata_o <= count_low_byte0_reg;
                `DTCU_ADDR_HI0:  sfr_rdata_o <= count_high_byte0_reg;
                `DTCU_ADDR_LO1:  sfr_rdata_o <= count_low_byte1_reg;
                `DTCU_ADDR_HI1:  sfr_rdata_o <= count_high_byte1_reg;
                default:         sfr_rdata_o <= `DTCU_RD_UNMAPPED;
            endcase
        end
    end

    // flags straight from the control register
    assign first_overflow_flag_o  = timer_control_reg[`DTCU_CTRL_OVF0];
    assign second_overflow_flag_o = timer_control_reg[`DTCU_CTRL_OVF1];

endmodule // dtcu_timer_unit

`default_nettype wire

// file: dtcu_regs.vh
`ifndef DTCU_REGS_VH
`define DTCU_REGS_VH

// ---------------------------------------------------------------------------
// special function register addresses
// ---------------------------------------------------------------------------
`define DTCU_ADDR_CTRL      8'h88
`define DTCU_ADDR_MODE      8'h89
`define DTCU_ADDR_LO0       8'h8A
`define DTCU_ADDR_LO1       8'h8B
`define DTCU_ADDR_HI0       8'h8C
`define DTCU_ADDR_HI1       8'h8D

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define DTCU_RST_CTRL       8'h00
`define DTCU_RST_MODE       8'h00
`define DTCU_RST_BYTE       8'h00
`define DTCU_RD_UNMAPPED    8'h00

// ---------------------------------------------------------------------------
// control register bit positions
// ---------------------------------------------------------------------------
`define DTCU_CTRL_OVF1      7
`define DTCU_CTRL_RUN1      6
`define DTCU_CTRL_OVF0      5
`define DTCU_CTRL_RUN0      4

// ---------------------------------------------------------------------------
// mode register fields (per timer nibble, timer 1 in 7:4)
// ---------------------------------------------------------------------------
`define DTCU_MF_GATE        3
`define DTCU_MF_SEL         2
`define DTCU_MF_MODE_HI     1
`define DTCU_MF_MODE_LO     0
`define DTCU_MF_NIB1        4
`define DTCU_MODE_PRESC13   2'h0
`define DTCU_MODE_CASC16    2'h1
`define DTCU_MODE_RELOAD8   2'h2
`define DTCU_MODE_SPLIT     2'h3
`define DTCU_PRESC_MAX      5'h1F
`define DTCU_BYTE_MAX       8'hFF

// ---------------------------------------------------------------------------
// machine cycle timing: 12 core periods, phase index = (state-1)*2 + (p-1)
// ---------------------------------------------------------------------------
`define DTCU_CYC_LEN        4'hC
`define DTCU_PHASE_ZERO     4'h0
`define DTCU_PHASE_LAST     4'hB
`define DTCU_SAMPLE_PHASE   4'h9
`define DTCU_UPDATE_PHASE   4'h4

`endif

// file: dtcu_pin_sampler.v
`timescale 1ns/1ns
`default_nettype none

// ---------------------------------------------------------------------------
// pin synchroniser, filter and per machine cycle sampler
// ---------------------------------------------------------------------------
module dtcu_pin_sampler (
    // clock and reset
    input  wire       ref_clk_i,
    input  wire       rst_n_i,
    // pin and sample strobe
    input  wire       pin_i,
    input  wire       sample_i,
    // results
    output wire       level_o,
    output wire       fall_o
);

    reg sync1_reg;
    reg sync2_reg;
    reg sync3_reg;
    reg filt_reg;
    reg samp_reg;
    reg fall_reg;

    // three stage synchroniser, level accepted when stages two and three agree
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
            filt_reg  <= 1'b0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            if (sync2_reg == sync3_reg) begin
                filt_reg <= sync3_reg;
            end
        end
    end

    // one sample per machine cycle, fall when high then low
    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            samp_reg <= 1'b0;
            fall_reg <= 1'b0;
        end else if (sample_i) begin
            samp_reg <= filt_reg;
            fall_reg <= samp_reg & ~filt_reg;
        end else begin
            fall_reg <= 1'b0;
        end
    end

    assign level_o = filt_reg;
    assign fall_o  = fall_reg;

endmodule // dtcu_pin_sampler

`default_nettype wire

// file: dtcu_pin_model.sv
`timescale 1ns/1ns
`default_nettype none

// ----------
// far side: count pulse source and gate levels
// ----------
module dtcu_pin_model (
    // clock
    input  wire logic       ref_clk_i,
    // control from the bench
    input  wire logic       run_i,
    input  wire logic [7:0] hold_i,
    input  wire logic [1:0] gate_i,
    // pins toward the timers
    output logic            first_count_input_o,
    output logic            second_count_input_o,
    output logic            first_ext_irq_pin_o,
    output logic            second_ext_irq_pin_o
);
    logic [7:0] cnt_reg;
    logic       pin_reg;

    // square wave while running, pulled up high when idle
    always @(posedge ref_clk_i) begin
        if (!run_i) begin
            cnt_reg <= 8'h00;
            pin_reg <= 1'b1;
        end else if (cnt_reg == hold_i - 8'h01) begin
            cnt_reg <= 8'h00;
            pin_reg <= ~pin_reg;
        end else begin
            cnt_reg <= cnt_reg + 8'h01;
        end
    end

    // both count pins share one waveform
    assign first_count_input_o  = pin_reg;
    assign second_count_input_o = pin_reg;
    assign first_ext_irq_pin_o  = gate_i[0];
    assign second_ext_irq_pin_o = gate_i[1];
endmodule // dtcu_pin_model

`default_nettype wire

// file: dtcu_timer_unit_asserts.sv
`timescale 1ns/1ns
`default_nettype none

module dtcu_timer_unit_asserts (
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    // register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic       sfr_wr_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic       sfr_rd_i,
    input wire logic       sfr_bit_wr_i,
    input wire logic [2:0] sfr_bit_sel_i,
    input wire logic       sfr_bit_val_i,
    input wire logic [7:0] sfr_rdata_o,
    // acks and flags
    input wire logic       first_vector_ack_i,
    input wire logic       second_vector_ack_i,
    input wire logic       first_overflow_flag_o,
    input wire logic       second_overflow_flag_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    // ----------
    // machine cycle phase tracker
    // ----------
    logic [3:0] ph_reg;

    // counts 0..11 from reset, like the core phase counter
    always @(posedge ref_clk_i) begin
        if (!rst_n_i || ph_reg == 4'hB)
            ph_reg <= 4'h0;
        else
            ph_reg <= ph_reg + 4'h1;
    end

    // ----------
    // properties
    // ----------
    sequence s_mode_wr_rd;
        sfr_wr_i && sfr_addr_i == 8'h89 ##1 !sfr_wr_i ##1 sfr_rd_i && sfr_addr_i == 8'h89;
    endsequence

    AST_MODE_RDBK: assert property (s_mode_wr_rd |=> sfr_rdata_o == $past(sfr_wdata_i, 3))
        else $error("mode register read back differs");
    AST_RST_ZERO: assert property ($rose(rst_n_i) |-> sfr_rdata_o == 8'h00 && !first_overflow_flag_o
        && !second_overflow_flag_o) else $error("state not zero after reset");
    AST_RD_HOLD: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without a read");
    AST_UNMAPPED: assert property (sfr_rd_i && (sfr_addr_i < 8'h88 || sfr_addr_i > 8'h8D)
        |=> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
    AST_OVF0_PHASE: assert property ($rose(first_overflow_flag_o)
        |-> $past(ph_reg) == 4'h4 || $past(sfr_wr_i || sfr_bit_wr_i)) else $error("first flag set off phase");
    AST_OVF1_PHASE: assert property ($rose(second_overflow_flag_o)
        |-> $past(ph_reg) == 4'h4 || $past(sfr_wr_i || sfr_bit_wr_i)) else $error("second flag set off phase");
    AST_ACK0_CLR: assert property (first_vector_ack_i && ph_reg != 4'h4 && !sfr_wr_i && !sfr_bit_wr_i
        |=> !first_overflow_flag_o) else $error("first flag not cleared by ack");
    AST_ACK1_CLR: assert property (second_vector_ack_i && ph_reg != 4'h4 && !sfr_wr_i && !sfr_bit_wr_i
        |=> !second_overflow_flag_o) else $error("second flag not cleared by ack");
    AST_BIT_WR: assert property (sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i == 8'h88
        && sfr_bit_sel_i == 3'h5 && !first_vector_ack_i && ph_reg != 4'h4
        |=> first_overflow_flag_o == $past(sfr_bit_val_i)) else $error("bit write missed flag");
endmodule // dtcu_timer_unit_asserts

bind dtcu_timer_unit dtcu_timer_unit_asserts chk_u (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
    .sfr_wdata_i(sfr_wdata_i), .sfr_rd_i(sfr_rd_i), .sfr_bit_wr_i(sfr_bit_wr_i),
    .sfr_bit_sel_i(sfr_bit_sel_i), .sfr_bit_val_i(sfr_bit_val_i), .sfr_rdata_o(sfr_rdata_o),
    .first_vector_ack_i(first_vector_ack_i), .second_vector_ack_i(second_vector_ack_i),
    .first_overflow_flag_o(first_overflow_flag_o), .second_overflow_flag_o(second_overflow_flag_o)
);

`default_nettype wire

// file: dual_timer_counter_unit_bench.sv
`timescale 1ns/1ns
`default_nettype none

module dual_timer_counter_unit_bench;
    // ----------
    // bench signals
    // ----------
    logic       ref_clk_i;
    logic       rst_n_i;
    logic [7:0] addr, wdata, hold, a;
    logic [2:0] bsel;
    logic [1:0] gate;
    logic       wr, rd, bwr, bval, ack0, ack1, prun;
    wire  [7:0] rdata;
    wire        cnt0, cnt1, irq0, irq1, ovf0, ovf1;
    int         errors = 0;
    int         checks_done = 0;
    int         cyc = 0;
    int         n;

    // design and far side pins
    dtcu_timer_unit dut_u (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .sfr_addr_i(addr), .sfr_wr_i(wr),
        .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel),
        .sfr_bit_val_i(bval), .sfr_rdata_o(rdata), .first_vector_ack_i(ack0),
        .second_vector_ack_i(ack1), .first_count_input_i(cnt0), .second_count_input_i(cnt1),
        .first_ext_irq_pin_i(irq0), .second_ext_irq_pin_i(irq1),
        .first_overflow_flag_o(ovf0), .second_overflow_flag_o(ovf1)
    );
    dtcu_pin_model pins_u (
        .ref_clk_i(ref_clk_i), .run_i(prun), .hold_i(hold), .gate_i(gate),
        .first_count_input_o(cnt0), .second_count_input_o(cnt1),
        .first_ext_irq_pin_o(irq0), .second_ext_irq_pin_o(irq1)
    );

    // core clock
    initial begin
        ref_clk_i = 1'b0;
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    // hang guard
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors = errors + 1;
            tally_and_finish();
        end
    end

    // ----------
    // tasks, each entered and left at a rising edge
    // ----------
    task automatic tally_and_finish;
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
            errors = errors + 1;
        end
    endtask
    task automatic wr_b(input logic [7:0] ad, input logic [7:0] d);
        addr  <= ad;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i) wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic rd_b(input logic [7:0] ad, input logic [7:0] exp);
        addr <= ad;
        rd   <= 1'b1;
        @(posedge ref_clk_i) rd <= 1'b0;
        @(posedge ref_clk_i);
        chk($sformatf("sfr %h", ad), exp, rdata);
    endtask
    task automatic bw(input logic [2:0] s, input logic v);
        addr <= 8'h88;
        bsel <= s;
        bval <= v;
        bwr  <= 1'b1;
        @(posedge ref_clk_i) bwr <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic ack(input logic w);
        ack0 <= !w;
        ack1 <= w;
        @(posedge ref_clk_i) {ack0, ack1} <= 2'h0;
        @(posedge ref_clk_i);
        chk($sformatf("flag%0d", w), 8'h00, {7'h00, w ? ovf1 : ovf0});
    endtask
    task automatic wflag(input logic w);
        for (n = 0; n < 60 && (w ? ovf1 : ovf0) !== 1'b1; n++)
            @(posedge ref_clk_i);
        chk($sformatf("flag%0d", w), 8'h01, {7'h00, w ? ovf1 : ovf0});
    endtask
    task automatic pins(input int c);
        prun <= 1'b1;
        repeat (c) @(posedge ref_clk_i);
        prun <= 1'b0;
        repeat (40) @(posedge ref_clk_i);
    endtask

    // ----------
    // main sequence
    // ----------
    initial begin
        {wr, rd, bwr, bval, ack0, ack1, prun} = 7'h00;
        {addr, wdata, bsel, gate} = 21'h0;
        hold = 8'h18;
        rst_n_i = 1'b0;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        wr_b(8'h8E, 8'hFF);
        for (a = 8'h88; a < 8'h8F; a++) rd_b(a, 8'h00);
        wr_b(8'h89, 8'hA5);
        rd_b(8'h89, 8'hA5);
        wr_b(8'h88, 8'h0F);
        rd_b(8'h88, 8'h0F);
        bw(3'h5, 1'b1);
        chk("flag0", 8'h01, {7'h00, ovf0});
        bw(3'h5, 1'b0);
        // 16 bit timer: wrap then five machine cycles
        wr_b(8'h89, 8'h01);
        wr_b(8'h8A, 8'hFF);
        wr_b(8'h8C, 8'hFF);
        bw(3'h4, 1'b1);
        wflag(1'b0);
        repeat (60) @(posedge ref_clk_i);
        bw(3'h4, 1'b0);
        repeat (24) @(posedge ref_clk_i);
        rd_b(8'h8A, 8'h05);
        rd_b(8'h8C, 8'h00);
        ack(1'b0);
        // 8 bit reload on the second timer
        wr_b(8'h89, 8'h20);
        wr_b(8'h8B, 8'hFD);
        wr_b(8'h8D, 8'hFD);
        bw(3'h6, 1'b1);
        wflag(1'b1);
        bw(3'h6, 1'b0);
        rd_b(8'h8B, 8'hFD);
        rd_b(8'h8D, 8'hFD);
        ack(1'b1);
        // 13 bit timer: prescaler carries into high byte
        wr_b(8'h8A, 8'hFF);
        wr_b(8'h8C, 8'hFF);
        bw(3'h4, 1'b1);
        wflag(1'b0);
        bw(3'h4, 1'b0);
        rd_b(8'h8A, 8'hE0);
        rd_b(8'h8C, 8'h00);
        // event counting, first timer gated by its irq pin
        wr_b(8'h89, 8'h5D);
        wr_b(8'h8A, 8'h00);
        wr_b(8'h8B, 8'h00);
        wr_b(8'h88, 8'h50);
        pins(192);
        rd_b(8'h8B, 8'h04);
        rd_b(8'h8A, 8'h00);
        gate <= 2'h1;
        pins(192);
        rd_b(8'h8B, 8'h08);
        rd_b(8'h8A, 8'h04);
        // split mode: second timer holds, first high byte on second run bit
        wr_b(8'h88, 8'h00);
        wr_b(8'h89, 8'h33);
        wr_b(8'h8A, 8'hFF);
        wr_b(8'h8C, 8'hFF);
        wr_b(8'h88, 8'h50);
        wflag(1'b0);
        wflag(1'b1);
        wr_b(8'h88, 8'h00);
        rd_b(8'h8B, 8'h08);
        rd_b(8'h8A, 8'h00);
        rd_b(8'h8C, 8'h00);
        tally_and_finish();
    end
endmodule // dual_timer_counter_unit_bench

`default_nettype wire
